// ### rtl/rst_seq_pkg.sv
// Constants, types and register map for the reset sequencer.
package rst_seq_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CAUSE   = 8'h00;
    localparam logic [7:0] IDX_CONTROL = 8'h01;
    localparam logic [7:0] IDX_CONFIG  = 8'h02;
    localparam logic [7:0] IDX_STATE   = 8'h03;
    localparam logic [7:0] IDX_UNLOCK  = 8'h04;

    // Cause flag bit positions.
    localparam int BIT_POWER_ON = 0;
    localparam int BIT_PIN      = 1;
    localparam int BIT_BROWNOUT = 2;
    localparam int BIT_WATCHDOG = 3;
    localparam int BIT_DEBUG    = 4;
    localparam int BIT_SW       = 5;
    localparam int BIT_SW_TRIG  = 0;

    // Reset values.
    localparam logic [7:0] CAUSE_RESET = 8'h01;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // Startup delay codes, low-power clock counts and the system clock count.
    localparam logic [1:0] DLY_64K  = 2'h0;
    localparam logic [1:0] DLY_4K   = 2'h1;
    localparam logic [1:0] DLY_RSVD = 2'h2;
    localparam logic [1:0] DLY_NONE = 2'h3;
    localparam logic [16:0] LP_CYCLES_64K = 17'h10000;
    localparam logic [16:0] LP_CYCLES_4K  = 17'h01000;
    localparam logic [4:0]  SYS_CYCLES    = 5'h18;

    // Brownout mode codes.
    localparam logic [1:0] BRN_RSVD     = 2'h0;
    localparam logic [1:0] BRN_SAMPLED  = 2'h1;
    localparam logic [1:0] BRN_ENABLED  = 2'h2;
    localparam logic [1:0] BRN_DISABLED = 2'h3;
    localparam logic [2:0] BRN_LEVEL_LOWEST = 3'h7;

    // Timed unlock: key value and window length in cycles.
    localparam logic [7:0] UNLOCK_KEY    = 8'hd8;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

    // Oscillator startup and calibration load times in cycles.
    localparam logic [3:0] OSC_START_CYCLES = 4'h8;
    localparam logic [3:0] CAL_LOAD_CYCLES  = 4'h2;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_HOLD,
        ST_LP_DELAY,
        ST_SYS_DELAY,
        ST_OSC_START,
        ST_CAL_LOAD,
        ST_RUN
    } seq_state_t;

    // Fuse settings presented to the block.
    typedef struct packed {
        logic [1:0] startup_delay_sel;
        logic [2:0] brownout_level_sel;
        logic [1:0] brownout_active_mode_sel;
        logic [1:0] brownout_sleep_mode_sel;
    } fuse_set_t;

    // Raw reset sources, all from outside the clock domain.
    typedef struct packed {
        logic power_on_detect;
        logic pin_low;
        logic brownout_below;
        logic watchdog_timeout;
        logic debug_reset;
    } reset_src_t;

endpackage

// ### rtl/reset_sequencer_with_sources.sv
// Reset controller: source collection, release sequence and cause flags.
// Behaviour
// - Any request resets at once and holds.
// - After release: counter, oscillator start, calibration.
// - New request restarts the sequence from the top.
// - Delay on low-power clock plus 24 clocks.
// - Code selects 64K, 4K, reserved, none.
// - Reset selects the 2MHz oscillator clock.
// - Start oscillator then load calibration row.
// - Power-on detect acts as reset request.
// - Disabled brownout forced on in erase/debug.
// - Brownout resets at once, releases via counter.
// - Level code 111 lowest, 000 highest.
// - Level change ignored while programming mode.
// - Sampled mode powers detector per edge.
// - Sampled detection switches to continuous mode.
// - Active setting in active/idle, else sleep.
// - Mode codes: reserved, sampled, enabled, disabled.
// - Filtered low pin holds a reset request.
// - Watchdog request lasts one to two cycles.
// - Software reset issued within two clocks.
// - No instruction runs before software reset.
// - Sticky cause flags cleared by power-on or one.
// - Power-on flag clears only by writing one.
// - Trigger bit self-clears when reset issued.
// - Trigger write needs timed unlock first.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module reset_sequencer_with_sources
    import rst_seq_pkg::*;
#(
    parameter int PIN_FILTER_CYCLES = 4
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire reset_src_t  src_raw,
    input  wire fuse_set_t   fuses,
    input  wire logic        low_power_osc,
    input  wire logic        sleep_deep,
    input  wire logic        prog_mode,
    input  wire logic        chip_erase,
    input  wire logic        debug_enabled,
    input  wire logic        osc_ready,
    output logic             system_reset_n,
    output logic             cpu_halt,
    output logic             osc_2m_select,
    output logic             osc_2m_enable,
    output logic             cal_load,
    output logic             brownout_power,
    output logic [2:0]       brownout_level
);

    // Reset release through two flops.
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Two-flop synchronisers for the reset sources and the low-power clock.
    logic [5:0] in_meta_q;
    logic [5:0] in_sync_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            in_meta_q <= 6'h00;
            in_sync_q <= 6'h00;
        end else begin
            in_meta_q <= {low_power_osc, src_raw};
            in_sync_q <= in_meta_q;
        end
    end
    logic por_s;
    logic pin_s;
    logic brn_s;
    logic wd_s;
    logic dbg_s;
    logic lp_s;
    assign {lp_s, por_s, pin_s, brn_s, wd_s, dbg_s} = in_sync_q;

    // Low-power clock rising edge detect, taken after the synchroniser.
    logic lp_prev_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            lp_prev_q <= 1'b0;
        end else begin
            lp_prev_q <= lp_s;
        end
    end
    logic lp_edge;
    assign lp_edge = lp_s & ~lp_prev_q;

    // Pin must stay low longer than the minimum pulse before it counts.
    logic [7:0] pin_cnt_q;
    logic       pin_req_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pin_cnt_q <= 8'h00;
            pin_req_q <= 1'b0;
        end else if (!pin_s) begin
            pin_cnt_q <= 8'h00;
            pin_req_q <= 1'b0;
        end else if (pin_cnt_q >= 8'(PIN_FILTER_CYCLES)) begin
            pin_req_q <= 1'b1;
        end else begin
            pin_cnt_q <= pin_cnt_q + 8'h01;
        end
    end

    // Brownout mode picks active or sleep setting; disabled is overridden.
    function automatic logic [1:0] brn_mode(input fuse_set_t f,
                                            input logic deep,
                                            input logic force_on);
        logic [1:0] m;
        m = deep ? f.brownout_sleep_mode_sel
                 : f.brownout_active_mode_sel;
        if (force_on) begin
            m = BRN_ENABLED;
        end
        return m;
    endfunction

    logic       brn_force;
    logic [1:0] brn_mode_cur;
    assign brn_force = (chip_erase | debug_enabled) &
        (brn_mode(fuses, sleep_deep, 1'b0) == BRN_DISABLED);
    assign brn_mode_cur = brn_mode(fuses, sleep_deep, brn_force);

    // Level latched outside programming mode; forced lowest when overridden.
    logic [2:0] level_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            level_q <= BRN_LEVEL_LOWEST;
        end else if (brn_force) begin
            level_q <= BRN_LEVEL_LOWEST;
        end else if (!prog_mode) begin
            level_q <= fuses.brownout_level_sel;
        end
    end

    // Brownout detector: sampled mode powers up per edge, latches on trip.
    logic brn_cont_q;
    logic brn_pwr_q;
    logic brn_req_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            brn_cont_q <= 1'b0;
            brn_pwr_q  <= 1'b0;
            brn_req_q  <= 1'b0;
        end else begin
            unique case (brn_mode_cur)
                BRN_ENABLED: begin
                    brn_pwr_q <= 1'b1;
                    brn_req_q <= brn_s;
                end
                BRN_SAMPLED: begin
                    brn_pwr_q <= lp_edge | brn_cont_q;
                    if (brn_cont_q) begin
                        brn_req_q  <= brn_s;
                        brn_cont_q <= brn_s;
                    end else if (lp_edge && brn_s) begin
                        brn_req_q  <= 1'b1;
                        brn_cont_q <= 1'b1;
                    end
                end
                default: begin
                    brn_pwr_q  <= 1'b0;
                    brn_req_q  <= 1'b0;
                    brn_cont_q <= 1'b0;
                end
            endcase
        end
    end

    // Watchdog pulse stretched by one cycle into the request.
    logic [1:0] wd_hold_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wd_hold_q <= 2'h0;
        end else if (wd_s) begin
            wd_hold_q <= 2'h2;
        end else if (wd_hold_q != 2'h0) begin
            wd_hold_q <= wd_hold_q - 2'h1;
        end
    end

    // APB decode, shared by write and read paths.
    logic       wr_en;
    logic       known;
    assign wr_en = psel & penable & pwrite;
    assign known = (paddr[1:0] == 2'h0) && (paddr[7:2] <= IDX_UNLOCK[5:0]);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
        return a == {idx[5:0], 2'h0};
    endfunction

    // Timed unlock window opened by writing the key.
    logic [2:0] unlock_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            unlock_q <= 3'h0;
        end else if (wr_en && hit(paddr, IDX_UNLOCK) &&
                     pwdata[7:0] == UNLOCK_KEY) begin
            unlock_q <= UNLOCK_CYCLES;
        end else if (unlock_q != 3'h0) begin
            unlock_q <= unlock_q - 3'h1;
        end
    end

    // Software trigger, one-cycle issue then held off by the reset itself.
    logic sw_trig_q;
    logic sw_req_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sw_trig_q <= 1'b0;
            sw_req_q  <= 1'b0;
        end else begin
            sw_req_q <= sw_trig_q;
            if (sw_trig_q) begin
                sw_trig_q <= 1'b0;
            end else if (wr_en && hit(paddr, IDX_CONTROL) &&
                         unlock_q != 3'h0) begin
                sw_trig_q <= pwdata[BIT_SW_TRIG];
            end
        end
    end

    // Combined request; debug only from the programmer source, not the pin path.
    logic any_req;
    assign any_req = por_s | pin_req_q | brn_req_q | (wd_hold_q != 2'h0)
                   | dbg_s | sw_req_q;

    // Startup delay setting, written by software, steers the counter.
    logic [1:0] dly_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            dly_q <= CONFIG_RESET[1:0];
        end else if (!por_s && wr_en && hit(paddr, IDX_CONFIG)) begin
            dly_q <= pwdata[1:0];
        end
    end

    function automatic logic [16:0] lp_target(input logic [1:0] code);
        unique case (code)
            DLY_64K:  return LP_CYCLES_64K;
            DLY_4K:   return LP_CYCLES_4K;
            DLY_RSVD: return LP_CYCLES_64K;
            default:  return 17'h00000;
        endcase
    endfunction

    // Release sequencer.
    seq_state_t state_q;
    logic [16:0] cnt_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= ST_HOLD;
            cnt_q   <= 17'h00000;
        end else if (any_req) begin
            state_q <= ST_HOLD;
            cnt_q   <= 17'h00000;
        end else begin
            unique case (state_q)
                ST_HOLD: begin
                    state_q <= (lp_target(dly_q) == 17'h00000)
                             ? ST_SYS_DELAY : ST_LP_DELAY;
                    cnt_q   <= 17'h00000;
                end
                ST_LP_DELAY: begin
                    if (cnt_q == lp_target(dly_q)) begin
                        state_q <= ST_SYS_DELAY;
                        cnt_q   <= 17'h00000;
                    end else if (lp_edge) begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                end
                ST_SYS_DELAY: begin
                    if (cnt_q == 17'(SYS_CYCLES - 5'h01)) begin
                        state_q <= ST_OSC_START;
                        cnt_q   <= 17'h00000;
                    end else begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                end
                ST_OSC_START: begin
                    if (osc_ready &&
                        cnt_q >= 17'(OSC_START_CYCLES)) begin
                        state_q <= ST_CAL_LOAD;
                        cnt_q   <= 17'h00000;
                    end else begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                end
                ST_CAL_LOAD: begin
                    if (cnt_q == 17'(CAL_LOAD_CYCLES)) begin
                        state_q <= ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 17'h00001;
                    end
                end
                ST_RUN: begin
                    cnt_q <= 17'h00000;
                end
            endcase
        end
    end

    // Registered outputs toward the rest of the chip.
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            system_reset_n <= 1'b0;
            cpu_halt       <= 1'b1;
            osc_2m_select  <= 1'b1;
            osc_2m_enable  <= 1'b0;
            cal_load       <= 1'b0;
            brownout_power <= 1'b0;
            brownout_level <= BRN_LEVEL_LOWEST;
        end else begin
            system_reset_n <= ~any_req && state_q == ST_RUN;
            cpu_halt       <= any_req || sw_trig_q ||
                              state_q != ST_RUN;
            osc_2m_select  <= 1'b1;
            osc_2m_enable  <= ~any_req && (state_q == ST_OSC_START ||
                              state_q == ST_CAL_LOAD ||
                              state_q == ST_RUN);
            cal_load       <= ~any_req && state_q == ST_CAL_LOAD;
            brownout_power <= brn_pwr_q;
            brownout_level <= level_q;
        end
    end

    // Sticky cause flags; set beats a same-cycle write-one clear.
    logic [7:0] cause_q;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    always_comb begin
        set_v = 8'h00;
        set_v[BIT_POWER_ON] = por_s;
        set_v[BIT_PIN]      = pin_req_q;
        set_v[BIT_BROWNOUT] = brn_req_q;
        set_v[BIT_WATCHDOG] = wd_hold_q != 2'h0;
        set_v[BIT_DEBUG]    = dbg_s;
        set_v[BIT_SW]       = sw_req_q;
        clr_v = (wr_en && hit(paddr, IDX_CAUSE)) ? pwdata[7:0] : 8'h00;
    end
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cause_q <= CAUSE_RESET;
        end else if (por_s) begin
            cause_q <= CAUSE_RESET;
        end else begin
            cause_q <= ((cause_q & ~clr_v) | set_v) & 8'h3f;
        end
    end

    // APB answer: zero wait states, error on unmapped or misaligned.
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            prdata  <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                if (hit(paddr, IDX_CAUSE)) begin
                    prdata <= {24'h000000, cause_q};
                end else if (hit(paddr, IDX_CONTROL)) begin
                    prdata <= {31'h00000000, sw_trig_q};
                end else if (hit(paddr, IDX_CONFIG)) begin
                    prdata <= {30'h00000000, dly_q};
                end else if (hit(paddr, IDX_STATE)) begin
                    prdata <= {24'h000000, level_q, brn_mode_cur,
                               state_q};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### sim/source_model.sv
// Far-side model: reset sources, the reset pin and the oscillator ready line.
`timescale 1ns/1ps
`default_nettype none

module source_model
    import rst_seq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       fire,
    input  wire logic [2:0] which,
    input  wire logic [7:0] len,
    input  wire logic       slow,
    input  wire logic       osc_2m_enable,
    output reset_src_t      src_raw,
    output logic            osc_ready
);
    logic [7:0] left_q;
    logic [2:0] kind_q;
    logic [4:0] osc_cnt_q;

    // A request is a level held for len cycles, longer than the pin filter.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left_q <= 8'h00;
            kind_q <= 3'h0;
        end else if (fire) begin
            left_q <= len;
            kind_q <= which;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end

    // One source at a time; bit 0 is the debug programmer, never software.
    always_comb begin
        src_raw = '0;
        if (left_q != 8'h00) begin
            src_raw = reset_src_t'(5'h01 << kind_q);
        end
    end

    // A slow oscillator settles after 20 enabled cycles.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_cnt_q <= 5'h00;
        end else if (!osc_2m_enable) begin
            osc_cnt_q <= 5'h00;
        end else if (osc_cnt_q != 5'h1f) begin
            osc_cnt_q <= osc_cnt_q + 5'h01;
        end
    end
    assign osc_ready = osc_2m_enable && (!slow || osc_cnt_q >= 5'h14);
endmodule

`default_nettype wire

// ### sim/rst_seq_asserts.sv
// Concurrent checks on the reset sequencer ports.
`timescale 1ns/1ps
`default_nettype none

module rst_seq_asserts
    import rst_seq_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire reset_src_t  src_raw,
    input wire fuse_set_t   fuses,
    input wire logic        sleep_deep,
    input wire logic        prog_mode,
    input wire logic        chip_erase,
    input wire logic        debug_enabled,
    input wire logic        system_reset_n,
    input wire logic        cpu_halt,
    input wire logic        osc_2m_select,
    input wire logic        osc_2m_enable,
    input wire logic        cal_load,
    input wire logic        brownout_power,
    input wire logic [2:0]  brownout_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    por_resets_a: assert property (
        src_raw.power_on_detect |-> ##[1:5] !system_reset_n)
        else $error("power-on detect did not reset");
    req_holds_a: assert property (
        src_raw.debug_reset [*5] |-> !system_reset_n)
        else $error("reset not held during request");
    cal_after_osc_a: assert property (
        cal_load |-> osc_2m_enable)
        else $error("calibration without oscillator");
    release_order_a: assert property (
        $rose(system_reset_n) |-> $past(cal_load) || $past(cal_load, 2))
        else $error("release not after calibration");
    cal_length_a: assert property (
        $rose(cal_load) |-> cal_load [*3] ##1 !cal_load)
        else $error("calibration stage length wrong");
    osc_select_a: assert property (
        osc_2m_select) else $error("internal oscillator not selected");
    halt_in_reset_a: assert property (
        !system_reset_n |-> cpu_halt) else $error("cpu runs in reset");
    brn_forced_a: assert property (
        ((chip_erase || debug_enabled) && !prog_mode && ((sleep_deep ?
        fuses.brownout_sleep_mode_sel : fuses.brownout_active_mode_sel)
        == BRN_DISABLED)) [*4] |-> brownout_power
        && brownout_level == BRN_LEVEL_LOWEST)
        else $error("brownout not forced on");
    level_frozen_a: assert property (
        prog_mode && $past(prog_mode) && !chip_erase && !debug_enabled
        && !$past(chip_erase) && !$past(debug_enabled)
        |-> $stable(brownout_level))
        else $error("level changed in programming mode");
    brn_resets_a: assert property (
        (!sleep_deep && fuses.brownout_active_mode_sel == BRN_ENABLED
        && src_raw.brownout_below) [*5] |-> !system_reset_n)
        else $error("brownout did not reset");
    apb_no_wait_a: assert property (
        psel && !penable |=> pready && penable)
        else $error("access cycle without pready");
    err_with_ready_a: assert property (
        pslverr |-> pready) else $error("pslverr without pready");
endmodule

bind reset_sequencer_with_sources rst_seq_asserts chk_u (.*);

`default_nettype wire

// ### sim/reset_sequencer_with_sources_tb.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/1ps
`default_nettype none

module reset_sequencer_with_sources_tb
    import rst_seq_pkg::*;
;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, len;
    logic [31:0] pwdata, prdata;
    reset_src_t  src_raw;
    fuse_set_t   fuses;
    logic        sleep_deep, prog_mode, chip_erase, debug_enabled, osc_ready;
    logic        system_reset_n, cpu_halt, osc_2m_select, osc_2m_enable;
    logic        cal_load, brownout_power, fire, slow;
    logic [2:0]  brownout_level, which;
    logic [1:0]  lp_div = 2'h0;
    wire         low_power_osc = lp_div[1];
    logic [33:0] exp_q[$];
    logic [33:0] note;
    int          n_errors, samples_checked, cyc, n, k, hi, seed;

    reset_sequencer_with_sources #(.PIN_FILTER_CYCLES(2)) dut_u (.*);
    source_model far_u (.*);

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ok(input string what, input logic cond);
        check(what, {31'h0, cond}, 32'h1);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One APB transfer; the expected answer is noted before the access edge.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic err);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        exp_q.push_back({!wr, err, e});
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [2:0] kind, input logic [7:0] l);
        @(posedge clk);
        fire <= 1'b1; which <= kind; len <= l;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    // Counts cycles until the chip leaves reset, bounded.
    task automatic wait_run(output int cnt);
        cnt = 0;
        while (system_reset_n !== 1'b1 && cnt < 20000) begin
            @(posedge clk);
            cnt++;
        end
        ok("release", cnt < 20000);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Results are taken in the access cycle, where they stand one cycle.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            if (note[33]) check("prdata", prdata, note[31:0]);
        end
    end
    always #20 clk = ~clk;
    always @(posedge clk) lp_div <= lp_div + 2'h1;
    // A hang counts as a mismatch; the 4K delay alone takes some 16K cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        clk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; fire = 0; which = 3'h0; len = 8'h00; slow = 0;
        sleep_deep = 0; prog_mode = 0; chip_erase = 0; debug_enabled = 0;
        fuses = '{2'h0, 3'h7, BRN_ENABLED, BRN_ENABLED};
        seed = 58905;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, 8'h00, 0, 32'h01, 0);
        apb(0, 8'h08, 0, 32'h00, 0);
        apb(1, 8'h14, 32'hff, 0, 1);
        apb(0, 8'h14, 0, 32'h00, 1);
        apb(1, 8'h08, 32'h3, 0, 0);
        // A pin request cuts the long first sequence short and restarts it.
        pulse(3'h3, 8'h0d);
        settle(15);
        check("held", {31'h0, system_reset_n}, 32'h0);
        wait_run(n);
        ok("short delay", n >= 35 && n <= 45);
        apb(1, 8'h00, 32'hc0, 0, 0);
        apb(0, 8'h00, 0, 32'h03, 0);
        apb(1, 8'h00, 32'h03, 0, 0);
        apb(0, 8'h00, 0, 32'h00, 0);
        for (k = 0; k < 4; k++) begin
            pulse(3'(k), 8'h0d + 8'($random(seed) & 7));
            settle(22);
            check("in reset", {31'h0, system_reset_n}, 32'h0);
            wait_run(n);
            apb(0, 8'h00, 0, 32'h1 << (4 - k), 0);
            apb(1, 8'h00, 32'h1 << (4 - k), 0, 0);
        end
        slow <= 1'b1;
        pulse(3'h3, 8'h0d);
        settle(15);
        wait_run(n);
        ok("slow osc", n >= 47);
        slow <= 1'b0;
        apb(1, 8'h04, 32'h1, 0, 0);
        settle(8);
        check("locked", {31'h0, system_reset_n}, 32'h1);
        apb(1, 8'h10, 32'hd8, 0, 0);
        apb(1, 8'h04, 32'h1, 0, 0);
        settle(2);
        check("halt", {31'h0, cpu_halt}, 32'h1);
        wait_run(n);
        apb(0, 8'h04, 0, 32'h00, 0);
        apb(0, 8'h00, 0, 32'h22, 0);
        pulse(3'h4, 8'h0d);
        settle(16);
        wait_run(n);
        apb(0, 8'h00, 0, 32'h01, 0);
        for (k = 0; k < 8; k++) begin
            fuses.brownout_level_sel <= 3'(k);
            settle(4);
            check("level", {29'h0, brownout_level}, 32'(k));
        end
        prog_mode <= 1'b1;
        fuses.brownout_level_sel <= 3'h2;
        settle(4);
        check("frozen", {29'h0, brownout_level}, 32'h7);
        prog_mode <= 1'b0;
        settle(4);
        check("applied", {29'h0, brownout_level}, 32'h2);
        fuses.brownout_active_mode_sel <= BRN_DISABLED;
        settle(4);
        check("off", {31'h0, brownout_power}, 32'h0);
        chip_erase <= 1'b1;
        settle(5);
        check("forced", {28'h0, brownout_power, brownout_level}, 32'hf);
        chip_erase <= 1'b0;
        debug_enabled <= 1'b1;
        settle(5);
        check("dbg forced", {31'h0, brownout_power}, 32'h1);
        debug_enabled <= 1'b0;
        fuses.brownout_active_mode_sel <= BRN_ENABLED;
        fuses.brownout_sleep_mode_sel <= BRN_DISABLED;
        sleep_deep <= 1'b1;
        settle(4);
        check("sleep set", {31'h0, brownout_power}, 32'h0);
        sleep_deep <= 1'b0;
        fuses.brownout_active_mode_sel <= BRN_SAMPLED;
        settle(8);
        hi = 0;
        for (k = 0; k < 40; k++) begin
            settle(1);
            hi += brownout_power;
        end
        ok("sampled", hi > 0 && hi < 40);
        pulse(3'h2, 8'h0d);
        settle(10);
        check("cont mode", {30'h0, brownout_power, system_reset_n}, 32'h2);
        wait_run(n);
        apb(1, 8'h08, 32'h1, 0, 0);
        pulse(3'h3, 8'h0d);
        settle(15);
        wait_run(n);
        ok("4K delay", n >= 16400 && n <= 16500);
        close_out();
    end
endmodule

`default_nettype wire
